// ==== rtl/macrocell_defs.svh ====
`ifndef MACROCELL_DEFS_SVH
`define MACROCELL_DEFS_SVH

// ********************************************************************
// Array dimensions.
// ********************************************************************
`define MC_COUNT 10
`define INPUT_PINS 10
`define SUM_TERMS 4

// ********************************************************************
// Reset values.
// ********************************************************************
`define STATE_RESET 1'h0
`define PIN_RESET 1'h1
`define DRIVE_RESET 1'h0
`define SYNC_RESET 1'h0
`define SYNC_N_RESET 1'h1
`define CLK_TERM_RESET 1'h1

// ********************************************************************
// Flip-flop levels set by reset and preset.
// ********************************************************************
`define LEVEL_RESET 1'h0
`define LEVEL_PRESET 1'h1

`endif

// ==== rtl/macrocell_pkg.sv ====
`include "macrocell_defs.svh"

package macrocell_pkg;

  // Product terms that the logic array delivers to one macrocell.
  typedef struct packed {
    logic [`SUM_TERMS-1:0] sum;
    logic clock;
    logic reset;
    logic preset;
    logic oe;
  } pterm_t;

  // Operating mode of one macrocell in the current cycle.
  typedef enum logic [5:0] {
    MODE_REG = 6'h01,
    MODE_RESET = 6'h02,
    MODE_PRESET = 6'h04,
    MODE_COMB = 6'h08,
    MODE_LOAD = 6'h10,
    MODE_KEEP = 6'h20
  } mode_t;

endpackage

// ==== rtl/registered_macrocell_array.sv ====
`timescale 1ns/1ns
`include "macrocell_defs.svh"

// Summary of operation
// - Ten cells, each flip-flop with own controls.
// - Data is OR of four terms, XORed.
// - Ten inputs, ten switchable I/O pins.
// - Capture on own clock term rising edge.
// - Clock terms may use pins and feedback.
// - Polarity zero active low, one active high.
// - Pin is inverse of flip-flop state.
// - Polarity affects clocked data capture and the bypass path.
// - Drive needs own enable and low pin.
// - Shared enable high floats all outputs.
// - Reset and preset act on level.
// - Reset gives zero, preset gives one.
// - Both active bypasses flip-flop to output.
// - Combinatorial mode follows terms one edge late.
// - Preload low loads undriven flip-flops from pins.
// - Low pin presets, high pin resets.
// - Enabled output keeps state during preload.
// - Every pin has own path; cells identical.

module registered_macrocell_array (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Dedicated input pins and shared control pins.
  input wire logic [`INPUT_PINS-1:0] input_pin,
  input wire logic output_enable_n,
  input wire logic preload_n,
  // Programmable I/O pins.
  input wire logic [`MC_COUNT-1:0] io_in,
  output logic [`MC_COUNT-1:0] io_out,
  output logic [`MC_COUNT-1:0] io_oe,
  // Product terms from the logic array, one set per cell.
  input wire macrocell_pkg::pterm_t [`MC_COUNT-1:0] terms,
  // Polarity bits, one per cell.
  input wire logic [`MC_COUNT-1:0] polarity,
  // Paths back into the logic array.
  output logic [`INPUT_PINS-1:0] input_to_array,
  output logic [`MC_COUNT-1:0] io_to_array,
  output logic [`MC_COUNT-1:0] feedback
);

  // ******************************************************************
  // Pin synchronisers.
  // ******************************************************************

  logic [`INPUT_PINS-1:0] input_meta_r;
  logic [`INPUT_PINS-1:0] input_sync_r;
  logic [`MC_COUNT-1:0] io_meta_r;
  logic [`MC_COUNT-1:0] io_sync_r;
  logic oe_n_meta_r;
  logic oe_n_sync_r;
  logic preload_n_meta_r;
  logic preload_n_sync_r;

  // Dedicated inputs pass two flip-flops before the array sees them.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      input_meta_r <= {`INPUT_PINS{`SYNC_RESET}};
      input_sync_r <= {`INPUT_PINS{`SYNC_RESET}};
    end else begin
      input_meta_r <= input_pin;
      input_sync_r <= input_meta_r;
    end
  end

  // I/O pin levels pass two flip-flops before use.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      io_meta_r <= {`MC_COUNT{`SYNC_RESET}};
      io_sync_r <= {`MC_COUNT{`SYNC_RESET}};
    end else begin
      io_meta_r <= io_in;
      io_sync_r <= io_meta_r;
    end
  end

  // Shared active-low controls reset to their inactive level.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oe_n_meta_r <= `SYNC_N_RESET;
      oe_n_sync_r <= `SYNC_N_RESET;
      preload_n_meta_r <= `SYNC_N_RESET;
      preload_n_sync_r <= `SYNC_N_RESET;
    end else begin
      oe_n_meta_r <= output_enable_n;
      oe_n_sync_r <= oe_n_meta_r;
      preload_n_meta_r <= preload_n;
      preload_n_sync_r <= preload_n_meta_r;
    end
  end

  // Each pin keeps its own path into the logic array.
  assign input_to_array = input_sync_r;
  assign io_to_array = io_sync_r;

  // ******************************************************************
  // Macrocell state.
  // ******************************************************************

  logic [`MC_COUNT-1:0] state_r;
  logic [`MC_COUNT-1:0] state_nxt;
  logic [`MC_COUNT-1:0] pin_r;
  logic [`MC_COUNT-1:0] pin_nxt;
  logic [`MC_COUNT-1:0] drive_r;
  logic [`MC_COUNT-1:0] drive_nxt;
  logic [`MC_COUNT-1:0] clk_term_r;
  logic [`MC_COUNT-1:0] clk_rise;
  logic [`MC_COUNT-1:0] xor_node;
  logic [`MC_COUNT-1:0] comb_sel;
  logic preload_act;
  logic [`MC_COUNT-1:0] rst_only;
  logic [`MC_COUNT-1:0] pre_only;

  // Preload is active while the synchronised pin is low.
  assign preload_act = !preload_n_sync_r;

  // Outputs come straight from the cell flip-flops.
  assign io_out = pin_r;
  assign io_oe = drive_r;
  assign feedback = state_r;

  // ******************************************************************
  // Assertion defaults.
  // ******************************************************************

  // Every check samples on the clock and sleeps through reset.
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!reset_n);

  // Each dedicated pin reaches the array two edges after sampling.
  chk_input_path: assert property (
    ($past(reset_n) && $past(reset_n, 2)) |->
    (input_to_array == $past(input_pin, 2)))
    else $error("input pin path not two stages deep");

  // Each I/O pin level reaches the array two edges after sampling.
  chk_io_path: assert property (
    ($past(reset_n) && $past(reset_n, 2)) |->
    (io_to_array == $past(io_in, 2)))
    else $error("io pin path not two stages deep");

  // A high shared enable pin floats every driver once synchronised.
  chk_shared_all: assert property (
    ($past(reset_n) && $past(reset_n, 2) && $past(output_enable_n, 2))
    |=> !(|io_oe))
    else $error("driver enabled while shared enable pin high");

  // ******************************************************************
  // Identical cells, one per I/O pin.
  // ******************************************************************

  genvar i;
  generate
    for (i = 0; i < `MC_COUNT; i++) begin : gen_cell
      macrocell_pkg::mode_t mode;

      // Sum of four terms through the polarity gate.
      assign xor_node[i] = (|terms[i].sum) ^ polarity[i];

      // A rising clock term is seen against its value last cycle.
      assign clk_rise[i] = terms[i].clock && !clk_term_r[i];

      // Both terms active select the register bypass.
      assign comb_sel[i] = terms[i].reset && terms[i].preset;
      assign rst_only[i] = terms[i].reset && !terms[i].preset;
      assign pre_only[i] = terms[i].preset && !terms[i].reset;

      // Mode decode; preload outranks every other cell input.
      always_comb begin
        if (preload_act && !drive_r[i]) begin
          mode = macrocell_pkg::MODE_LOAD;
        end else if (preload_act) begin
          mode = macrocell_pkg::MODE_KEEP;
        end else if (comb_sel[i]) begin
          mode = macrocell_pkg::MODE_COMB;
        end else if (terms[i].reset) begin
          mode = macrocell_pkg::MODE_RESET;
        end else if (terms[i].preset) begin
          mode = macrocell_pkg::MODE_PRESET;
        end else begin
          mode = macrocell_pkg::MODE_REG;
        end
      end

      // Next flip-flop state; only clocked capture sees polarity.
      always_comb begin
        case (mode)
          macrocell_pkg::MODE_LOAD: begin
            state_nxt[i] = !io_sync_r[i];
          end
          macrocell_pkg::MODE_KEEP: begin
            state_nxt[i] = state_r[i];
          end
          macrocell_pkg::MODE_COMB: begin
            state_nxt[i] = state_r[i];
          end
          macrocell_pkg::MODE_RESET: begin
            state_nxt[i] = `LEVEL_RESET;
          end
          macrocell_pkg::MODE_PRESET: begin
            state_nxt[i] = `LEVEL_PRESET;
          end
          macrocell_pkg::MODE_REG: begin
            state_nxt[i] = clk_rise[i] ? xor_node[i] : state_r[i];
          end
          default: begin
            state_nxt[i] = state_r[i];
          end
        endcase
      end

      // The inverting buffer drives the bypass or the register.
      always_comb begin
        if (comb_sel[i] && !preload_act) begin
          pin_nxt[i] = !xor_node[i];
        end else begin
          pin_nxt[i] = !state_nxt[i];
        end
      end

      // Own enable term gated by the shared active-low pin.
      assign drive_nxt[i] = terms[i].oe && !oe_n_sync_r;

      // Cell flip-flop with its own clock term.
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          state_r[i] <= `STATE_RESET;
        end else begin
          state_r[i] <= state_nxt[i];
        end
      end

      // Clock term history for edge detection.
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          clk_term_r[i] <= `CLK_TERM_RESET;
        end else begin
          clk_term_r[i] <= terms[i].clock;
        end
      end

      // Registered pin level and driver enable.
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pin_r[i] <= `PIN_RESET;
          drive_r[i] <= `DRIVE_RESET;
        end else begin
          pin_r[i] <= pin_nxt[i];
          drive_r[i] <= drive_nxt[i];
        end
      end

      // **************************************************************
      // Checks for this cell.
      // **************************************************************

      chk_drive_gated: assert property (
        (terms[i].oe && !oe_n_sync_r) |=> drive_r[i] ##0
        (io_oe[i] == drive_r[i]))
        else $error("cell driver not enabled by both enables");

      chk_enable_off: assert property (
        !terms[i].oe |=> !io_oe[i])
        else $error("cell driven without its enable term");

      chk_shared_float: assert property (
        oe_n_sync_r [*2] |-> ##1 !io_oe[i])
        else $error("cell output driven while shared enable high");

      chk_reset_level: assert property (
        (rst_only[i] && !preload_act) |=> (!state_r[i] && io_out[i]))
        else $error("reset term did not clear cell");

      chk_preset_level: assert property (
        (pre_only[i] && !preload_act) |=> (state_r[i] && !io_out[i]))
        else $error("preset term did not set cell");

      chk_reset_holds: assert property (
        (rst_only[i] && !preload_act) [*3] |=> !state_r[i])
        else $error("reset term level not held");

      chk_preset_holds: assert property (
        (pre_only[i] && !preload_act) [*3] |=> state_r[i])
        else $error("preset term level not held");

      chk_bypass_path: assert property (
        (comb_sel[i] && !preload_act) |=>
        (io_out[i] == !$past(xor_node[i]) && $stable(state_r[i])))
        else $error("bypass pin not inverse of polarity node");

      chk_clock_capture: assert property (
        (clk_rise[i] && !terms[i].reset && !terms[i].preset &&
        !preload_act) |=> (state_r[i] == $past(xor_node[i])))
        else $error("cell missed data on clock term edge");

      chk_no_edge_hold: assert property (
        (!clk_rise[i] && !terms[i].reset && !terms[i].preset &&
        !preload_act) |=> $stable(state_r[i]))
        else $error("cell changed without clock term edge");

      chk_pin_inverse: assert property (
        !(comb_sel[i] && !preload_act) |=> (io_out[i] == !state_r[i]))
        else $error("registered pin not inverse of state");

      chk_preload_load: assert property (
        (preload_act && !drive_r[i]) |=>
        (state_r[i] == !$past(io_sync_r[i])))
        else $error("preload did not follow pin level");

      chk_preload_keep: assert property (
        (preload_act && drive_r[i]) |=> $stable(state_r[i]))
        else $error("enabled cell changed during preload");

      chk_preload_rank: assert property (
        (preload_act && !drive_r[i] && terms[i].reset) |=>
        (state_r[i] == !$past(io_sync_r[i])))
        else $error("reset term overrode preload");

      chk_load_pin_level: assert property (
        (preload_act && !drive_r[i]) |=>
        (io_out[i] == $past(io_sync_r[i])))
        else $error("preloaded pin does not read back its level");

      cov_capture: cover property (
        clk_rise[i] && !terms[i].reset && !terms[i].preset &&
        !preload_act ##1 state_r[i]);

      cov_bypass: cover property (
        (comb_sel[i] && !preload_act) [*2] ##1 !comb_sel[i]);

      cov_preload: cover property (
        preload_act && !drive_r[i] && !io_sync_r[i] ##1 state_r[i]);

      cov_drive: cover property (
        !oe_n_sync_r && terms[i].oe ##1 io_oe[i]);

      cov_keep: cover property (
        (preload_act && drive_r[i]) [*2]);
    end
  endgenerate

endmodule // registered_macrocell_array

// ==== test/board_model.sv ====
`timescale 1ns/1ns

// ********************************************************************
// Board logic on the far side of the programmable I/O pins.
// ********************************************************************
module board_model (
  // Device side of each pin.
  input wire logic [9:0] io_out,
  input wire logic [9:0] io_oe,
  // Board drive, per pin.
  input wire logic [9:0] drive_val,
  input wire logic [9:0] drive_en,
  // Resolved pin level.
  output logic [9:0] io_in
);
  // The device driver wins, then the board, then the pull-up on the pin.
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (io_oe[i]) begin
        io_in[i] = io_out[i];
      end else if (drive_en[i]) begin
        io_in[i] = drive_val[i];
      end else begin
        io_in[i] = 1'h1;
      end
    end
  end
endmodule // board_model

// ==== test/registered_macrocell_array_tb_top.sv ====
`timescale 1ns/1ns

// ********************************************************************
// Bench for the registered macrocell array.
// ********************************************************************
module registered_macrocell_array_tb_top;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [9:0] input_pin = 10'h000;
  logic output_enable_n = 1'h1;
  logic preload_n = 1'h1;
  logic [9:0] io_in;
  logic [9:0] io_out;
  logic [9:0] io_oe;
  macrocell_pkg::pterm_t [9:0] terms = '0;
  logic [9:0] polarity = 10'h000;
  logic [9:0] input_to_array;
  logic [9:0] io_to_array;
  logic [9:0] feedback;
  logic [9:0] drive_val = 10'h000;
  logic [9:0] drive_en = 10'h000;
  int num_errors = 0;
  int checks_done = 0;
  // Rows: sum[7:4], reset[3], preset[2], polarity[1], expected pin[0].
  logic [7:0] rows [8] = '{8'h10, 8'h01, 8'h83, 8'h02,
                           8'h0b, 8'h46, 8'h2c, 8'h0d};

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  registered_macrocell_array i_dut (
    .clk(clk), .reset_n(reset_n), .input_pin(input_pin),
    .output_enable_n(output_enable_n), .preload_n(preload_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .terms(terms),
    .polarity(polarity), .input_to_array(input_to_array),
    .io_to_array(io_to_array), .feedback(feedback)
  );

  board_model i_board (
    .io_out(io_out), .io_oe(io_oe), .drive_val(drive_val),
    .drive_en(drive_en), .io_in(io_in)
  );

  // Drives the same sum, clock, reset and preset terms into every cell, and each cell its own enable term, at the next rising edge.
  task automatic set_all(input logic [3:0] s, input logic c,
                         input logic r, input logic p,
                         input logic [9:0] o, input logic pl);
    @(posedge clk);
    polarity <= {10{pl}};
    for (int i = 0; i < 10; i++) begin
      terms[i] <= macrocell_pkg::pterm_t'({s, c, r, p, o[i]});
    end
  endtask

  // Lets n edges pass, then samples settled outputs.
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Compares one 10-bit result against its expected value.
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short after far more than the tests need.
  initial begin
    #(400 * 50);
    num_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    stop_test();
  end

  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    wait_n(2);
    check(io_out, 10'h3ff);
    check(io_oe, 10'h000);
    check(feedback, 10'h000);
    end_test("reset");
    // Table cases: a clean clock term edge in every cell per row.
    for (int k = 0; k < 8; k++) begin
      set_all(rows[k][7:4], 1'h0, rows[k][3], rows[k][2], 10'h000,
              rows[k][1]);
      set_all(rows[k][7:4], 1'h1, rows[k][3], rows[k][2], 10'h000,
              rows[k][1]);
      wait_n(3);
      check(io_out, {10{rows[k][0]}});
    end
    end_test("table");
    // Only cell 3 sees a clock edge; the others keep their state.
    set_all(4'h0, 1'h0, 1'h1, 1'h0, 10'h000, 1'h0);
    set_all(4'h1, 1'h0, 1'h0, 1'h0, 10'h000, 1'h0);
    @(posedge clk);
    terms[3].clock <= 1'h1;
    wait_n(3);
    check(feedback, 10'h008);
    check(io_out, 10'h3f7);
    end_test("own_clock");
    // Bypass follows the data one edge late, then registered output returns.
    set_all(4'h1, 1'h0, 1'h1, 1'h1, 10'h000, 1'h0);
    wait_n(3);
    check(io_out, 10'h000);
    check(feedback, 10'h008);
    set_all(4'h0, 1'h0, 1'h1, 1'h1, 10'h000, 1'h0);
    wait_n(3);
    check(io_out, 10'h3ff);
    set_all(4'h0, 1'h0, 1'h0, 1'h0, 10'h000, 1'h0);
    wait_n(3);
    check(io_out, 10'h3f7);
    end_test("bypass");
    // Per-cell enable terms gated by the shared enable pin.
    set_all(4'h0, 1'h0, 1'h0, 1'h0, 10'h01f, 1'h0);
    @(posedge clk);
    output_enable_n <= 1'h0;
    wait_n(4);
    check(io_oe, 10'h01f);
    @(posedge clk);
    output_enable_n <= 1'h1;
    wait_n(4);
    check(io_oe, 10'h000);
    @(posedge clk);
    output_enable_n <= 1'h0;
    input_pin <= 10'h3c5;
    wait_n(4);
    check(io_oe, 10'h01f);
    check(input_to_array, 10'h3c5);
    end_test("enable");
    // Preload: cells 0 to 4 stay driven and must keep their state.
    @(posedge clk);
    drive_val <= 10'h2a5;
    drive_en <= 10'h3e0;
    preload_n <= 1'h0;
    wait_n(4);
    set_all(4'h0, 1'h0, 1'h1, 1'h0, 10'h01f, 1'h0);
    wait_n(3);
    check(feedback, 10'h148);
    check(io_to_array, 10'h2b7);
    set_all(4'h0, 1'h0, 1'h0, 1'h0, 10'h01f, 1'h0);
    wait_n(2);
    @(posedge clk);
    preload_n <= 1'h1;
    wait_n(4);
    check(io_out, 10'h2b7);
    end_test("preload");
    stop_test();
  end
endmodule // registered_macrocell_array_tb_top
